// File: hw/fcdp_loader.sv
// Configuration data port top: serial, master parallel and peripheral entry.
// Assumes clk is the system clock and link_clk the free-running config source.
`timescale 1ns/10ps
`include "fcdp_params.svh"
module fcdp_loader #(
	parameter logic [15:0] PRE_BITS   = `FCDP_PRE_BITS,
	parameter logic [15:0] FRAME_BITS = `FCDP_FRAME_BITS,
	parameter logic [15:0] NUM_FRAMES = `FCDP_NUM_FRAMES
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        link_clk,
	input  wire logic [1:0]  mode_sel,
	input  wire logic        serial_din,
	input  wire logic [7:1]  parallel_config_byte,
	input  wire logic        chip_select_low_a_n,
	input  wire logic        chip_select_low_b_n,
	input  wire logic        chip_select_low_c_n_in,
	input  wire logic        write_strobe_high_in,
	input  wire logic        init_in,
	input  wire logic        done_in,
	output logic             config_clock,
	output logic             config_clock_oe_n,
	output logic             serial_dout,
	output logic             serial_dout_oe_n,
	output logic [15:2]      prom_address_out,
	output logic             prom_address_oe_n,
	output logic             write_strobe_high_out,
	output logic             chip_select_low_c_out,
	output logic             addr_low_oe_n,
	output logic             addr_advance,
	output logic             addr_advance_oe_n,
	output logic             ready_busy,
	output logic             ready_busy_oe_n,
	output logic             low_during_config,
	output logic             low_during_config_oe_n,
	output logic             init_out,
	output logic             init_oe_n,
	output logic             done_out,
	output logic             done_oe_n,
	output logic             user_pullup_en,
	output logic             user_outputs_hiz
);
	// Link-domain reset, taken from the system reset through two stages
	logic lrst_s1_q;  // First stage, read only by the second
	logic lrst_s2_q;  // Usable link reset, active low

	// Link-domain pin synchronisers
	logic [1:0] mode_s1_q;
	logic [1:0] mode_s2_q;
	logic [7:0] pbyte_s1_q;  // Parallel byte, bit 0 from serial pin
	logic [7:0] pbyte_s2_q;
	logic       init_s1_q;
	logic       init_s2_q;
	logic       done_s1_q;
	logic       done_s2_q;
	logic       req_s1_q;    // Peripheral byte request toggle
	logic       req_s2_q;

	// Link-domain engine
	logic       start_q;     // Hold-off passed, clock running
	logic       primed_q;    // First rise passed; sync lag makes it repeat bit 0
	logic       config_clock_q;      // Divided configuration clock
	logic       fwd_bit_q;   // Bit waiting for the falling edge
	logic       fwd_pend_q;  // That bit is to be forwarded
	logic       dout_q;      // Forwarded stream bit
	logic [7:0] sh_q;        // Byte being serialised
	logic [3:0] sh_cnt_q;    // Bits left in sh_q
	logic [15:0] addr_q;     // EPROM address
	logic       rclk_q;      // Address-advance strobe
	logic [3:0] settle_q;    // EPROM access wait
	fcdp_pkg::fcdp_mp_e mp_q;
	logic       ack_q;       // Peripheral byte acknowledge toggle
	logic       own_done_q;  // Own done, drives done pin low until then
	logic       release_q;   // Configuration over, pins handed to user
	logic       periph_q;    // Peripheral configuration in progress

	// System-domain peripheral capture
	logic [3:0] ctl_s1_q;    // Write controls, first stage
	logic [3:0] ctl_s2_q;
	logic [7:0] dat_s1_q;
	logic [7:0] dat_s2_q;
	logic       ack_s1_q;
	logic       ack_s2_q;
	logic       per_s1_q;
	logic       per_s2_q;
	logic       armed_q;     // All four controls seen asserted
	logic [7:0] pbuf_q;      // Captured byte, held for the link side
	logic       req_q;       // Request toggle

	fcdp_bit_if bits ();

	// Mode decode on synchronised straps
	wire mode_mser   = (mode_s2_q == `FCDP_MODE_MSER);
	wire mode_mpar   = (mode_s2_q == `FCDP_MODE_MPAR);
	wire mode_periph = (mode_s2_q == `FCDP_MODE_PERIPH);
	wire mode_serial = mode_mser || (mode_s2_q == `FCDP_MODE_SLAVE);
	wire running     = start_q && !release_q;
	wire rise_w      = running && !config_clock_q;
	wire fall_w      = running && config_clock_q;
	wire halted      = bits.frame_err;
	wire byte_bit    = sh_cnt_q != 4'h0;
	wire per_new     = mode_periph && (req_s2_q != ack_q) && !byte_bit;
	wire mp_load     = mode_mpar && (mp_q == fcdp_pkg::MP_LOAD);

	// Serial pin in serial modes, serialised byte otherwise
	assign bits.bit_valid = rise_w && !halted && (mode_serial ? primed_q : byte_bit);
	assign bits.bit_data  = mode_serial ? pbyte_s2_q[0] : sh_q[0];

	fcdp_frame_chk #(
		.PRE_BITS   (PRE_BITS),
		.FRAME_BITS (FRAME_BITS),
		.NUM_FRAMES (NUM_FRAMES)
	) u_chk (
		.clk   (link_clk),
		.rst_n (lrst_s2_q),
		.bits  (bits.chk)
	);

	// Link reset and pin synchronisers
	always_ff @(posedge link_clk)
	begin
		lrst_s1_q  <= rst_n;
		lrst_s2_q  <= lrst_s1_q;
		mode_s1_q  <= mode_sel;
		mode_s2_q  <= mode_s1_q;
		pbyte_s1_q <= {parallel_config_byte, serial_din};
		pbyte_s2_q <= pbyte_s1_q;
		init_s1_q  <= init_in;
		init_s2_q  <= init_s1_q;
		done_s1_q  <= done_in;
		done_s2_q  <= done_s1_q;
		req_s1_q   <= req_q;
		req_s2_q   <= req_s1_q;
	end

	// Start once the wired init line goes high; divided clock keeps running after an error
	always_ff @(posedge link_clk)
	begin
		if (!lrst_s2_q)
		begin
			start_q  <= 1'b0;
			primed_q <= 1'b0;
			config_clock_q   <= 1'b0;
		end
		else
		begin
			start_q  <= start_q || init_s2_q;
			// The first rise saw the PROM before its first step
			primed_q <= primed_q || rise_w;
			if (running)
				config_clock_q <= !config_clock_q; // PROM steps on each rise
		end
	end

	// Sample on the rise, forward on the next fall
	always_ff @(posedge link_clk)
	begin
		if (!lrst_s2_q)
		begin
			fwd_bit_q  <= 1'b1;
			fwd_pend_q <= 1'b0;
			dout_q     <= 1'b1;
		end
		else if (rise_w)
		begin
			// Input taken one rise after the PROM stepped
			fwd_bit_q  <= bits.bit_data;
			fwd_pend_q <= bits.fwd_valid;
		end
		else if (fall_w && fwd_pend_q)
			dout_q <= fwd_bit_q; // 1.5 periods behind, on the fall
	end

	// Byte shifter shared by master parallel and peripheral entry
	always_ff @(posedge link_clk)
	begin
		if (!lrst_s2_q)
		begin
			sh_q     <= 8'h00;
			sh_cnt_q <= 4'h0;
			ack_q    <= 1'b0;
		end
		else if (per_new)
		begin
			// Stable buffered byte taken from the system side
			sh_q     <= pbuf_q;
			sh_cnt_q <= 4'h8;
			ack_q    <= req_s2_q;
		end
		else if (mp_load)
		begin
			sh_q     <= pbyte_s2_q;
			sh_cnt_q <= 4'h8;
		end
		else if (bits.bit_valid && byte_bit)
		begin
			// Low bit goes first
			sh_q     <= {1'b0, sh_q[7:1]};
			sh_cnt_q <= sh_cnt_q - 4'h1;
		end
	end

	// Master parallel fetch: strobe, step address, wait, load
	always_ff @(posedge link_clk)
	begin
		if (!lrst_s2_q)
		begin
			mp_q     <= fcdp_pkg::MP_WAIT;
			addr_q   <= 16'h0000;
			rclk_q   <= 1'b0;
			settle_q <= 4'h0;
		end
		else if (mode_mpar && running && !halted)
		begin
			unique case (mp_q)
				fcdp_pkg::MP_WAIT:
				begin
					settle_q <= settle_q + 4'h1;
					if (settle_q == `FCDP_MP_SETTLE)
						mp_q <= fcdp_pkg::MP_LOAD;
				end
				fcdp_pkg::MP_LOAD:
					mp_q <= fcdp_pkg::MP_REQ;
				fcdp_pkg::MP_REQ:
				begin
					// Wait until the byte is fully shifted out
					settle_q <= 4'h0;
					if (!byte_bit)
					begin
						rclk_q <= 1'b1; // Strobe rises first
						mp_q   <= fcdp_pkg::MP_ADDR;
					end
				end
				fcdp_pkg::MP_ADDR:
				begin
					rclk_q <= 1'b0;
					addr_q <= addr_q + 16'h0001;
					mp_q   <= fcdp_pkg::MP_WAIT;
				end
			endcase
		end
	end

	// Done, then release on the first fall once the synchronised done line is high
	always_ff @(posedge link_clk)
	begin
		if (!lrst_s2_q)
		begin
			own_done_q <= 1'b0;
			release_q  <= 1'b0;
			periph_q   <= 1'b0;
		end
		else
		begin
			if (bits.own_done)
				own_done_q <= 1'b1;
			if (own_done_q && done_s2_q && fall_w)
				release_q <= 1'b1;
			// Peripheral activity level, crossed to the system side
			periph_q <= mode_periph && !release_q;
		end
	end

	// Pin drive, all from flip-flops; enables low while driving
	always_ff @(posedge link_clk)
	begin
		if (!lrst_s2_q)
		begin
			config_clock           <= 1'b0;
			config_clock_oe_n      <= 1'b1;
			serial_dout            <= 1'b1;
			serial_dout_oe_n       <= 1'b1;
			prom_address_out       <= 14'h0000;
			prom_address_oe_n      <= 1'b1;
			write_strobe_high_out  <= 1'b0;
			chip_select_low_c_out  <= 1'b0;
			addr_low_oe_n          <= 1'b1;
			addr_advance           <= 1'b0;
			addr_advance_oe_n      <= 1'b1;
			low_during_config      <= 1'b0;
			low_during_config_oe_n <= 1'b0;
			init_out               <= 1'b0;
			init_oe_n              <= 1'b1;
			done_out               <= 1'b0;
			done_oe_n              <= 1'b0;
			user_pullup_en         <= 1'b1;
			user_outputs_hiz       <= 1'b1;
		end
		else
		begin
			config_clock      <= config_clock_q;
			config_clock_oe_n <= release_q || !mode_mser;
			serial_dout       <= dout_q;
			serial_dout_oe_n  <= release_q;
			prom_address_out  <= addr_q[15:2];
			prom_address_oe_n <= release_q || !mode_mpar;
			// Low address bits leave on the strobe and third select
			write_strobe_high_out <= addr_q[0];
			chip_select_low_c_out <= addr_q[1];
			addr_low_oe_n         <= release_q || !mode_mpar;
			addr_advance          <= rclk_q;
			addr_advance_oe_n     <= release_q || !mode_mpar;
			// Low while loading, a constant high output afterwards
			low_during_config      <= release_q;
			// Frame error pulls the init line low
			init_oe_n <= !halted;
			done_oe_n <= own_done_q;
			// Pull-ups and tri-state hold until release
			user_pullup_en   <= !release_q;
			user_outputs_hiz <= !release_q;
		end
	end

	// System-domain synchronisers for host pins and link levels
	always_ff @(posedge clk)
	begin
		ctl_s1_q <= {chip_select_low_a_n, chip_select_low_b_n, chip_select_low_c_n_in, write_strobe_high_in};
		ctl_s2_q <= ctl_s1_q;
		dat_s1_q <= {parallel_config_byte, serial_din};
		dat_s2_q <= dat_s1_q;
		ack_s1_q <= ack_q;
		ack_s2_q <= ack_s1_q;
		per_s1_q <= periph_q;
		per_s2_q <= per_s1_q;
	end

	// Write starts when all four controls are asserted
	wire all_on  = (ctl_s2_q == 4'h1);
	wire pending = (req_q != ack_s2_q);

	// Byte capture on the first control to let go
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			armed_q <= 1'b0;
			pbuf_q  <= 8'h00;
			req_q   <= 1'b0;
		end
		else if (!per_s2_q)
			armed_q <= 1'b0;
		else if (all_on)
			armed_q <= 1'b1;
		else if (armed_q)
		begin
			armed_q <= 1'b0;
			// Write during busy is dropped
			if (!pending)
			begin
				pbuf_q <= dat_s2_q;
				req_q  <= !req_q;
			end
		end
	end

	// Ready/busy to the host, high means ready
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			ready_busy      <= 1'b0;
			ready_busy_oe_n <= 1'b1;
		end
		else
		begin
			ready_busy      <= !(pending || (armed_q && !all_on));
			ready_busy_oe_n <= !per_s2_q;
		end
	end
endmodule

// File: hw/fcdp_params.svh
// Constants for the configuration data port: stream layout, codes.
// Assumes inclusion by bare name from every design file that needs it.
//
// How it works
// - Serial input sampled on following clock rise
// - Preamble and overflow bits forwarded downstream
// - Forwarded data changes on falling clock edge
// - Low-during-config output stays high afterward
// - Done asserted one clock before outputs release; here release waits for the synchronised done line, then a fall
// - Three low selects plus high strobe start write
// - Byte latched when any control deasserts
// - Strobe and third select carry address bits
// - Ready/busy output tells host about acceptance
// - Address-advance strobe rises before address change
// - Sixteen-bit address driven to parallel EPROM
// - Serial input pin doubles as byte bit 0
// - Configuration pins released after configuration ends
// - Weak pull-ups enabled until configuration ends
// - Unused outputs tri-stated with pull-up meanwhile
// - Wired initialization line holds off master start
// - Stream opens with forty-bit preamble, then frames
// - Frame must end 111, else init low
`ifndef FCDP_PARAMS_SVH
`define FCDP_PARAMS_SVH
`define FCDP_PRE_BITS    16'h0028
`define FCDP_FRAME_BITS  16'h0020
`define FCDP_NUM_FRAMES  16'h0004
`define FCDP_STOP_PAT    3'h7
`define FCDP_MP_SETTLE   4'h3
`define FCDP_MODE_MSER   2'h0
`define FCDP_MODE_MPAR   2'h1
`define FCDP_MODE_PERIPH 2'h2
`define FCDP_MODE_SLAVE  2'h3
`endif

// File: hw/fcdp_pkg.sv
// Types shared by the configuration data port modules.
// Assumes the constants header is compiled alongside.
package fcdp_pkg;
	typedef enum logic [2:0] {CHK_PRE, CHK_SEEK, CHK_FRAME, CHK_OVER, CHK_ERR} fcdp_chk_e;
	typedef enum logic [1:0] {MP_WAIT, MP_LOAD, MP_REQ, MP_ADDR} fcdp_mp_e;
endpackage

// File: hw/fcdp_bit_if.sv
// Bit stream between the loader engine and the frame checker.
// Assumes both ends sit on the link clock.
`timescale 1ns/10ps
interface fcdp_bit_if;
	logic bit_valid;  // Stream bit taken this cycle
	logic bit_data;   // Value of that bit
	logic fwd_valid;  // Bit belongs to preamble or overflow
	logic own_done;   // Own frames all loaded
	logic frame_err;  // Stop pattern mismatch seen
	modport chk (input bit_valid, input bit_data, output fwd_valid, output own_done, output frame_err);
	modport eng (output bit_valid, output bit_data, input fwd_valid, input own_done, input frame_err);
endinterface

// File: hw/fcdp_frame_chk.sv
// Frame checker: walks preamble, own frames and overflow of the stream.
// Assumes one bit_valid per configuration clock rise, same clock.
`timescale 1ns/10ps
`include "fcdp_params.svh"
module fcdp_frame_chk #(
	parameter logic [15:0] PRE_BITS   = `FCDP_PRE_BITS,
	parameter logic [15:0] FRAME_BITS = `FCDP_FRAME_BITS,
	parameter logic [15:0] NUM_FRAMES = `FCDP_NUM_FRAMES
) (
	input  wire logic   clk,
	input  wire logic   rst_n,
	fcdp_bit_if.chk     bits
);
	fcdp_pkg::fcdp_chk_e state_q;   // Walk position
	logic [15:0]         cnt_q;     // Bits seen in preamble or frame
	logic [15:0]         frames_q;  // Own frames still to load
	logic [2:0]          tail_q;    // Last three frame bits
	wire  [2:0]          tail_d   = {tail_q[1:0], bits.bit_data};
	wire                 last_w   = (cnt_q == FRAME_BITS - 16'h0002);
	wire                 stop_ok  = (tail_d == `FCDP_STOP_PAT);

	// Preamble and overflow go downstream untouched
	assign bits.fwd_valid = bits.bit_valid && (state_q == fcdp_pkg::CHK_PRE || state_q == fcdp_pkg::CHK_OVER);
	assign bits.own_done  = (state_q == fcdp_pkg::CHK_OVER);
	assign bits.frame_err = (state_q == fcdp_pkg::CHK_ERR);

	// Stream walk
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state_q  <= fcdp_pkg::CHK_PRE;
			cnt_q    <= 16'h0000;
			frames_q <= NUM_FRAMES;
			tail_q   <= 3'h0;
		end
		else if (bits.bit_valid)
		begin
			unique case (state_q)
				fcdp_pkg::CHK_PRE:
				begin
					// Forty preamble bits before any frame
					cnt_q <= cnt_q + 16'h0001;
					if (cnt_q == PRE_BITS - 16'h0001)
						state_q <= fcdp_pkg::CHK_SEEK;
				end
				fcdp_pkg::CHK_SEEK:
				begin
					// A zero opens the frame
					cnt_q <= 16'h0000;
					if (!bits.bit_data)
						state_q <= fcdp_pkg::CHK_FRAME;
				end
				fcdp_pkg::CHK_FRAME:
				begin
					tail_q <= tail_d;
					cnt_q  <= cnt_q + 16'h0001;
					if (last_w)
					begin
						frames_q <= frames_q - 16'h0001;
						// Bad stop bits halt loading
						if (!stop_ok)
							state_q <= fcdp_pkg::CHK_ERR;
						else if (frames_q == 16'h0001)
							state_q <= fcdp_pkg::CHK_OVER;
						else
							state_q <= fcdp_pkg::CHK_SEEK;
					end
				end
				fcdp_pkg::CHK_OVER:
					state_q <= fcdp_pkg::CHK_OVER;
				fcdp_pkg::CHK_ERR:
					state_q <= fcdp_pkg::CHK_ERR;
				default:
					state_q <= fcdp_pkg::CHK_ERR;
			endcase
		end
	end
endmodule

// File: verification/fcdp_prom_model.sv
// Serial configuration PROM as seen from the loader's pins.
// Assumes its chip enable comes from the low-during-config output.
`timescale 1ns/10ps
module fcdp_prom_model (
	input  wire logic        rst_n,             // System reset restarts the address
	input  wire logic        config_clock,      // Clock from the loader
	input  wire logic        config_clock_oe_n, // Low while the loader drives it
	input  wire logic        chip_en_n,         // Active-low chip enable
	input  wire logic [79:0] stream,            // Contents, bit 0 first
	output logic             serial_out,        // Data towards the loader
	output int               rises              // Address counter
);
	// Address advances on every driven clock rise
	always @(posedge config_clock or negedge rst_n)
		if (!rst_n)
			rises <= 0;
		else if (!config_clock_oe_n)
			rises <= rises + 1;
	// Enabled: current bit; disabled or past the end: a moving pattern
	assign serial_out = (!chip_en_n && rises < 80) ? stream[rises] : rises[0];
endmodule

// File: verification/fcdp_loader_sva.sv
// Pin-level checker for the configuration data port top.
// Assumes mode_sel only changes while rst_n is low.
`timescale 1ns/10ps
`include "fcdp_params.svh"
module fcdp_loader_chk (
	input wire logic        link_clk,
	input wire logic        rst_n,
	input wire logic [1:0]  mode_sel,
	input wire logic        config_clock,
	input wire logic        config_clock_oe_n,
	input wire logic        serial_dout,
	input wire logic [15:2] prom_address_out,
	input wire logic        prom_address_oe_n,
	input wire logic        write_strobe_high_out,
	input wire logic        chip_select_low_c_out,
	input wire logic        addr_advance,
	input wire logic        ready_busy_oe_n,
	input wire logic        low_during_config,
	input wire logic        init_oe_n,
	input wire logic        done_oe_n,
	input wire logic        user_pullup_en,
	input wire logic        user_outputs_hiz
);
	// Whole EPROM address, low bits on the strobe and select pins
	wire logic [15:0] addr_w = {prom_address_out, chip_select_low_c_out, write_strobe_high_out};
	// Watched pins are link clock flops, except ready_busy_oe_n, which is a clk flop
	default clocking @(posedge link_clk); endclocking
	default disable iff (!rst_n);
	adv_step_a: assert property ($rose(addr_advance) |=> addr_w == $past(addr_w) + 16'h0001)
		else $error("address did not step after strobe");
	adv_first_a: assert property ($changed(addr_w) |-> $past(addr_advance))
		else $error("address changed without strobe");
	dout_fall_a: assert property ($changed(serial_dout) && mode_sel == `FCDP_MODE_MSER |-> $fell(config_clock))
		else $error("forwarded data moved off a falling edge");
	low_after_a: assert property (!user_pullup_en |-> low_during_config)
		else $error("low-during-config not high after start-up");
	pins_free_a: assert property (!user_pullup_en && !$past(user_pullup_en) |->
		config_clock_oe_n && prom_address_oe_n && ready_busy_oe_n && !user_outputs_hiz && $stable(config_clock))
		else $error("configuration pins not released");
	done_early_a: assert property ($fell(user_outputs_hiz) |-> done_oe_n)
		else $error("outputs active before done");
	err_hold_a: assert property (!init_oe_n |=> !init_oe_n && user_pullup_en && !done_oe_n)
		else $error("start-up after frame error");
	clk_mode_a: assert property (!config_clock_oe_n |-> mode_sel == `FCDP_MODE_MSER)
		else $error("clock driven outside master serial");
endmodule

bind fcdp_loader fcdp_loader_chk i_fcdp_loader_chk (
	.link_clk(link_clk), .rst_n(rst_n), .mode_sel(mode_sel), .config_clock(config_clock),
	.config_clock_oe_n(config_clock_oe_n), .serial_dout(serial_dout), .prom_address_out(prom_address_out),
	.prom_address_oe_n(prom_address_oe_n), .write_strobe_high_out(write_strobe_high_out),
	.chip_select_low_c_out(chip_select_low_c_out), .addr_advance(addr_advance), .ready_busy_oe_n(ready_busy_oe_n),
	.low_during_config(low_during_config), .init_oe_n(init_oe_n), .done_oe_n(done_oe_n),
	.user_pullup_en(user_pullup_en), .user_outputs_hiz(user_outputs_hiz)
);

// File: verification/fcdp_tb.sv
// Self-checking bench for the configuration data port top.
// Assumes the PROM model and the checker are compiled before it.
`timescale 1ns/10ps
`include "fcdp_params.svh"
module testbench;
	logic        clk;
	logic        link_clk;
	logic        rst_n = 1'b0;
	logic [1:0]  mode_sel = 2'h0;
	logic [7:0]  byte_q = 8'hFF;     // Byte on the data pins
	logic [3:0]  ctl_n = 4'hF;       // Write controls, low = asserted
	logic        init_ext = 1'b1;    // Slaves' share of the init line
	logic        done_ext = 1'b0;    // Downstream share of the done line
	logic [79:0] stream_q = '1;      // PROM contents
	logic [16:0] rnd = 17'h1789E;    // Random state
	logic        exp_q[$];           // Expected forwarded bits
	logic        wr_q[$];            // Writes awaiting busy
	int          bad_count = 0;
	int          checked = 0;
	int          rises;
	int          idx;
	wire logic [15:2] addr_hi;
	wire logic        cfg_clk, cfg_clk_oe_n, dout, a0, a1, addr_oe_n, rdy, rdy_oe_n;
	wire logic        lowcfg, lowcfg_oe_n, init_oe_n, done_oe_n, pull_en, prom_bit, sdo_oe_n, alow_oe_n;
	// Data pin 0: serial stream or byte bit 0
	wire logic        din = (mode_sel == `FCDP_MODE_MSER || mode_sel == `FCDP_MODE_SLAVE) ? prom_bit : byte_q[0];
	// Open-drain lines: low while any party pulls
	wire logic        init_in = init_ext & init_oe_n;
	wire logic        done_in = done_ext & done_oe_n;
	wire logic [15:0] addr_w = {addr_hi, a1, a0};
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial
	begin
		link_clk = 1'b0;
		#3.7;
		forever #6 link_clk = ~link_clk;
	end
	fcdp_loader #(.PRE_BITS(16'h0028), .FRAME_BITS(16'h0008), .NUM_FRAMES(16'h0001)) i_fcdp_loader (
		.clk(clk), .rst_n(rst_n), .link_clk(link_clk), .mode_sel(mode_sel), .serial_din(din),
		.parallel_config_byte(byte_q[7:1]), .chip_select_low_a_n(ctl_n[0]), .chip_select_low_b_n(ctl_n[1]),
		.chip_select_low_c_n_in(ctl_n[2]), .write_strobe_high_in(!ctl_n[3]), .init_in(init_in), .done_in(done_in),
		.config_clock(cfg_clk), .config_clock_oe_n(cfg_clk_oe_n), .serial_dout(dout), .serial_dout_oe_n(sdo_oe_n),
		.prom_address_out(addr_hi), .prom_address_oe_n(addr_oe_n), .write_strobe_high_out(a0),
		.chip_select_low_c_out(a1), .addr_low_oe_n(alow_oe_n), .addr_advance(), .addr_advance_oe_n(), .ready_busy(rdy),
		.ready_busy_oe_n(rdy_oe_n), .low_during_config(lowcfg), .low_during_config_oe_n(lowcfg_oe_n),
		.init_out(), .init_oe_n(init_oe_n), .done_out(), .done_oe_n(done_oe_n), .user_pullup_en(pull_en),
		.user_outputs_hiz()
	);
	fcdp_prom_model i_fcdp_prom_model (.rst_n(rst_n), .config_clock(cfg_clk), .config_clock_oe_n(cfg_clk_oe_n),
		.chip_en_n(lowcfg), .stream(stream_q), .serial_out(prom_bit), .rises(rises));
	function automatic logic [16:0] lfsr(input logic [16:0] s);
		return {s[15:0], s[16] ^ s[13]};
	endfunction
	task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp)
		begin
			bad_count++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic test_done();
		$display("Mismatches %0d of %0d checks", bad_count, checked);
		if (bad_count == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Reset into a mode; go sets the slaves' init share
	task automatic restart(input logic [1:0] m, input logic go);
		@(posedge clk);
		rst_n <= 1'b0;
		mode_sel <= m;
		init_ext <= go;
		done_ext <= 1'b0;
		ctl_n <= 4'hF;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		repeat (10) @(posedge clk);
	endtask
	// Preamble, one frame, overflow; bad breaks the last stop bit
	task automatic build(input logic bad);
		for (int i = 0; i < 80; i++)
		begin
			rnd = lfsr(rnd);
			stream_q[i] = (i == 40) ? 1'b0 : (i > 44 && i < 48) ? !(bad && i == 47) : rnd[0];
			if (!bad && (i < 40 || i > 47))
				exp_q.push_back(stream_q[i]);
		end
	endtask
	task automatic wait_rises(input int n);
		for (int i = 0; i < 3000 && rises < n; i++)
			@(posedge clk);
	endtask
	// Downstream capture on a driven rise: stream bit rises-2 is due
	always @(posedge cfg_clk)
	begin
		idx = rises - 2;
		if (!cfg_clk_oe_n && exp_q.size() > 0 && ((idx >= 0 && idx < 40) || (idx > 47 && idx < 80)))
			check("forwarded bit", {15'h0, exp_q.pop_front()}, {15'h0, dout});
	end
	// Each busy indication answers the oldest write and is driven to the host
	always @(negedge rdy)
		if (rst_n && wr_q.size() > 0)
			check("write busy", {15'h0, wr_q.pop_front()}, {15'h0, rdy_oe_n});
	// Watchdog
	initial
	begin
		#100000;
		bad_count++;
		test_done();
	end
	initial
	begin
		// Every mode code: pin ownership
		for (int m = 0; m < 4; m++)
		begin
			restart(2'(m), 1'b1);
			check("low cfg", 16'h0000, {14'h0, lowcfg, lowcfg_oe_n});
			check("pull-ups", 16'h0001, {15'h0, pull_en});
			repeat (400) @(posedge clk);
			check("clock oe", {15'h0, m != `FCDP_MODE_MSER}, {15'h0, cfg_clk_oe_n});
			check("address oe", {15'h0, m != `FCDP_MODE_MPAR}, {15'h0, addr_oe_n});
			check("low addr oe", {15'h0, m != `FCDP_MODE_MPAR}, {15'h0, alow_oe_n});
			check("busy oe", {15'h0, m != `FCDP_MODE_PERIPH}, {15'h0, rdy_oe_n});
			if (m == `FCDP_MODE_MPAR)
				check("address step", 16'h0001, {15'h0, addr_w > 16'h0003});
		end
		// Held off, then a clean stream and start-up
		build(1'b0);
		restart(`FCDP_MODE_MSER, 1'b0);
		repeat (40) @(posedge clk);
		check("held off", 16'h0000, 16'(rises));
		init_ext <= 1'b1;
		wait_rises(84);
		done_ext <= 1'b1;
		repeat (30) @(posedge clk);
		check("left over", 16'h0000, 16'(exp_q.size()));
		check("released", 16'h0000, {15'h0, pull_en});
		check("low cfg after", 16'h0001, {15'h0, lowcfg});
		check("done", 16'h0001, {15'h0, done_oe_n});
		check("dout oe", 16'h0001, {15'h0, sdo_oe_n});
		// Broken stop bit
		build(1'b1);
		restart(`FCDP_MODE_MSER, 1'b1);
		wait_rises(70);
		done_ext <= 1'b1;
		repeat (30) @(posedge clk);
		check("frame error", 16'h0007, {13'h0, !init_oe_n, !done_oe_n, pull_en});
		// Four writes, each ended by another control
		restart(`FCDP_MODE_PERIPH, 1'b1);
		for (int k = 0; k < 4; k++)
		begin
			for (int i = 0; i < 200 && rdy !== 1'b1; i++)
				@(posedge clk);
			rnd = lfsr(rnd);
			byte_q <= rnd[7:0];
			ctl_n <= 4'h0;
			wr_q.push_back(1'b0);
			repeat (4) @(posedge clk);
			ctl_n <= 4'h1 << k;
			repeat (2) @(posedge clk);
			ctl_n <= 4'hF;
			for (int i = 0; i < 20 && rdy !== 1'b0; i++)
				@(posedge clk);
		end
		repeat (40) @(posedge clk);
		check("writes taken", 16'h0000, 16'(wr_q.size()));
		check("ready again", 16'h0001, {15'h0, rdy});
		test_done();
	end
endmodule
